// File: core/fss_sweep.v
// frequency sweep sequencer: profile stepping, shape and output gating
//
// Notes on behaviour
// - sweep runs from start frequency up to start plus count times step
// - step interval is timed internally or paced by trigger pin
// - internal interval counts clock periods or output waveform cycles
// - in internal pacing one trigger pulse runs whole sweep unattended
// - external pacing: each later trigger rise advances one step
// - trigger-controlled burst: waveform while pin high, midscale while low
// - two shapes only: sawtooth or triangular
// - sawtooth steps up to end then jumps back to start
// - sawtooth cycle lasts count plus one intervals
// - triangular steps up to end then down to start, repeating
// - continuous mode holds each frequency full interval, phase unbroken
// - mode bit 7 low selects continuous output
// - mode bit high: burst for set time, then midscale, zero phase
// - trigger rise sampled by clock initialises and starts sweep
// - abort rise sampled by clock resets sweep, output midscale
//
// limitations
// - internal interval spans step_interval ticks plus one restart cycle
// - step_interval of zero acts as one tick
// - burst length counts the same ticks as the interval, so a wave-cycle
//   base gives a burst in waveform cycles, not clock periods
// - a triangle with a step count of zero behaves as a sawtooth
// - abort and a control write take priority over a start in the same cycle
// - trigger rises during an internally paced sweep are ignored
// - frequency arithmetic wraps at the word width; profiles that pass the
//   top of the range are the host's to avoid
`timescale 1ns/1ps
`include "fss_map.vh"
module fss_sweep (
  input wire clock,
  input wire rst,
  input wire trigger_pin,
  input wire abort_pin,
  input wire config_load,
  input wire [`FSS_FREQ_W-1:0] start_freq,
  input wire [`FSS_FREQ_W-1:0] step_size,
  input wire [`FSS_CNT_W-1:0] step_count,
  input wire [`FSS_INT_W-1:0] step_interval,
  input wire [`FSS_INT_W-1:0] burst_len,
  input wire interval_base,
  input wire ext_pacing,
  input wire shape_tri,
  input wire [11:0] control_bits,
  input wire pin_burst,
  input wire wave_tick,
  output reg [`FSS_FREQ_W-1:0] freq_word,
  output reg wave_enable,
  output reg phase_clear,
  output reg sweep_active,
  output reg step_pulse,
  output reg sweep_end
);
  localparam ST_IDLE = 2'b00;
  localparam ST_UP = 2'b01;
  localparam ST_DOWN = 2'b10;

  wire trig_lvl;
  wire trig_rise;
  wire abort_rise;
  wire output_mode_select;
  wire int_done;
  wire [`FSS_INT_W-1:0] int_count;
  reg advance;
  wire at_end;
  wire at_start;
  wire kill;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`FSS_CNT_W-1:0] step_cnt_q;
  reg [`FSS_CNT_W-1:0] step_cnt_d;
  reg [`FSS_FREQ_W-1:0] freq_d;
  reg restart_q;
  reg restart_d;
  reg step_pulse_d;
  reg sweep_end_d;
  reg active_d;
  reg wave_en_d;
  reg phase_clr_d;

  // frequency add or subtract, used for both directions
  function [`FSS_FREQ_W-1:0] fss_step;
    input [`FSS_FREQ_W-1:0] f;
    input [`FSS_FREQ_W-1:0] d;
    input down;
    begin
      if (down) begin
        fss_step = f - d;
      end else begin
        fss_step = f + d;
      end
    end
  endfunction

  // step counter compare, used for both sweep ends
  function fss_cnt_is;
    input [`FSS_CNT_W-1:0] cnt;
    input [`FSS_CNT_W-1:0] ref_cnt;
    begin
      fss_cnt_is = (cnt == ref_cnt);
    end
  endfunction

  // in the burst window while the interval count is below the burst length
  function fss_in_burst;
    input [`FSS_INT_W-1:0] cnt;
    input [`FSS_INT_W-1:0] len;
    begin
      fss_in_burst = (cnt < len);
    end
  endfunction

  fss_pin_sync u_trig (
    .clock(clock),
    .rst(rst),
    .pin(trigger_pin),
    .level(trig_lvl),
    .rise(trig_rise)
  );

  fss_pin_sync u_abort (
    .clock(clock),
    .rst(rst),
    .pin(abort_pin),
    .level(),
    .rise(abort_rise)
  );

  // interval timer restarts at every step and at sweep start
  fss_interval u_int (
    .clock(clock),
    .rst(rst),
    .restart(restart_q),
    .base_sel(interval_base),
    .wave_tick(wave_tick),
    .len(step_interval),
    .done(int_done),
    .count(int_count)
  );

  assign output_mode_select = control_bits[`FSS_MODE_BIT];
  // abort and a control write act alike
  assign kill = abort_rise || config_load;
  // pacing source: internal timer or trigger rise, never both
  always @* begin
    advance = 1'b0;
    if (state_q != ST_IDLE) begin
      if (ext_pacing) begin
        // host spacing between rises sets the interval
        advance = trig_rise;
      end else begin
        // one start pulse, then the timer runs the sweep alone
        advance = int_done;
      end
    end
  end
  assign at_end = fss_cnt_is(step_cnt_q, step_count);
  assign at_start = fss_cnt_is(step_cnt_q, `FSS_CNT_RST);

  // sweep state and step counter
  always @* begin
    state_d = state_q;
    step_cnt_d = step_cnt_q;
    freq_d = freq_word;
    if (kill) begin
      state_d = ST_IDLE;
      step_cnt_d = `FSS_CNT_RST;
      freq_d = start_freq;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (trig_rise) begin
            state_d = ST_UP;
            step_cnt_d = `FSS_CNT_RST;
            freq_d = start_freq;
          end
        end
        ST_UP: begin
          if (advance) begin
            if (!at_end) begin
              step_cnt_d = step_cnt_q + 12'h001;
              freq_d = fss_step(freq_word, step_size, 1'b0);
            end else if (shape_tri == `FSS_SHAPE_TRI && step_count != `FSS_CNT_RST) begin
              // end frequency held one interval, then walk down
              state_d = ST_DOWN;
              step_cnt_d = step_cnt_q - 12'h001;
              freq_d = fss_step(freq_word, step_size, 1'b1);
            end else begin
              // wrap straight to start: count+1 intervals per cycle
              step_cnt_d = `FSS_CNT_RST;
              freq_d = start_freq;
            end
          end
        end
        ST_DOWN: begin
          if (advance) begin
            if (at_start) begin
              state_d = ST_UP;
              step_cnt_d = step_cnt_q + 12'h001;
              freq_d = fss_step(freq_word, step_size, 1'b0);
            end else begin
              step_cnt_d = step_cnt_q - 12'h001;
              freq_d = fss_step(freq_word, step_size, 1'b1);
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // strobes and flags for the next cycle
  always @* begin
    restart_d = 1'b0;
    step_pulse_d = 1'b0;
    sweep_end_d = 1'b0;
    active_d = 1'b0;
    if (kill) begin
      // kill restarts the timer so a later start sees a clean count
      restart_d = 1'b1;
    end else begin
      if (state_q == ST_IDLE && trig_rise) begin
        restart_d = 1'b1;
      end
      if (advance) begin
        restart_d = 1'b1;
        step_pulse_d = 1'b1;
        if (state_q == ST_UP && at_end) begin
          sweep_end_d = 1'b1;
        end
      end
    end
    active_d = (state_d != ST_IDLE);
  end

  // output gating: midscale when idle, burst off-time, or pin low
  always @* begin
    wave_en_d = 1'b0;
    phase_clr_d = 1'b1;
    if (kill || state_d == ST_IDLE) begin
      // midscale and parked phase until the next start
      wave_en_d = 1'b0;
      phase_clr_d = 1'b1;
    end else if (pin_burst) begin
      // pin directly gates waveform
      wave_en_d = trig_lvl;
      phase_clr_d = !trig_lvl;
    end else if (output_mode_select == `FSS_MODE_BURST) begin
      // restart cycle parks the phase so every step opens at zero
      wave_en_d = !restart_q && fss_in_burst(int_count, burst_len);
      phase_clr_d = restart_q || !fss_in_burst(int_count, burst_len);
    end else begin
      // continuous: no phase clear at steps, so phase stays continuous
      wave_en_d = 1'b1;
      phase_clr_d = 1'b0;
    end
  end

  // registered sweep state and frequency word
  always @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      step_cnt_q <= `FSS_CNT_RST;
      freq_word <= `FSS_FREQ_RST;
    end else begin
      state_q <= state_d;
      step_cnt_q <= step_cnt_d;
      freq_word <= freq_d;
    end
  end

  // registered strobes; the timer restart lags a step by one cycle
  always @(posedge clock) begin
    if (rst) begin
      restart_q <= 1'b0;
      step_pulse <= 1'b0;
      sweep_end <= 1'b0;
      sweep_active <= 1'b0;
    end else begin
      restart_q <= restart_d;
      step_pulse <= step_pulse_d;
      sweep_end <= sweep_end_d;
      sweep_active <= active_d;
    end
  end

  // registered outputs; midscale out of reset
  always @(posedge clock) begin
    if (rst) begin
      wave_enable <= 1'b0;
      phase_clear <= 1'b1;
    end else begin
      wave_enable <= wave_en_d;
      phase_clear <= phase_clr_d;
    end
  end
endmodule

// File: core/fss_map.vh
// constants for the frequency sweep sequencer
`ifndef FSS_MAP_VH
`define FSS_MAP_VH
`define FSS_FREQ_W 24
`define FSS_CNT_W 12
`define FSS_INT_W 11
`define FSS_MODE_BIT 7
`define FSS_MODE_CONT 1'b0
`define FSS_MODE_BURST 1'b1
`define FSS_SHAPE_SAW 1'b0
`define FSS_SHAPE_TRI 1'b1
`define FSS_BASE_CLK 1'b0
`define FSS_BASE_WAVE 1'b1
`define FSS_FREQ_RST 24'h000000
`define FSS_CNT_RST 12'h000
`endif

// File: core/fss_pin_sync.v
// three-stage pin synchroniser with rising edge detect
`timescale 1ns/1ps
`include "fss_map.vh"
module fss_pin_sync (
  input wire clock,
  input wire rst,
  input wire pin,
  output wire level,
  output wire rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;
  // s1 only feeds s2; a change counts once s2 and s3 agree
  always @(posedge clock) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign level = lvl_q;
  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
endmodule

// File: core/fss_interval.v
// interval timer counting clock periods or output waveform cycles
`timescale 1ns/1ps
`include "fss_map.vh"
module fss_interval (
  input wire clock,
  input wire rst,
  input wire restart,
  input wire base_sel,
  input wire wave_tick,
  input wire [`FSS_INT_W-1:0] len,
  output wire done,
  output wire [`FSS_INT_W-1:0] count
);
  reg [`FSS_INT_W-1:0] cnt_q;
  wire tick;
  // wave base counts only on waveform cycle wraps
  assign tick = (base_sel == `FSS_BASE_WAVE) ? wave_tick : 1'b1;
  assign done = tick && (cnt_q + 11'h001 >= len) && !restart;
  assign count = cnt_q;
  always @(posedge clock) begin
    if (rst || restart || done) begin
      cnt_q <= 11'h000;
    end else if (tick) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end
endmodule

// File: tb/fss_sweep_sva.sv
// assertion checker for the frequency sweep sequencer
`timescale 1ns/1ps
`include "fss_map.vh"
module fss_sweep_sva (
  input wire clock,
  input wire rst,
  input wire trigger_pin,
  input wire abort_pin,
  input wire config_load,
  input wire [`FSS_FREQ_W-1:0] start_freq,
  input wire [`FSS_FREQ_W-1:0] step_size,
  input wire [`FSS_CNT_W-1:0] step_count,
  input wire shape_tri,
  input wire [`FSS_FREQ_W-1:0] freq_word,
  input wire wave_enable,
  input wire phase_clear,
  input wire sweep_active,
  input wire step_pulse,
  input wire sweep_end
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // reset itself is watched here, so the default disable is overridden
  a_reset_idle: assert property (disable iff (1'b0)
    rst |=> freq_word == 0 && !sweep_active && phase_clear) else $error("reset not idle");
  // midscale whenever no sweep runs
  a_idle_mid: assert property (!sweep_active |-> !wave_enable) else $error("idle out");
  // start and abort bounded by the three-stage pin sync
  a_trig_start: assert property (
    $rose(trigger_pin) && !sweep_active |-> ##[2:6] sweep_active) else $error("no start");
  a_abort_kill: assert property (
    $rose(abort_pin) |-> ##[1:6] !sweep_active) else $error("no abort");
  a_cfg_kill: assert property (
    config_load |-> ##[1:2] !sweep_active && !wave_enable) else $error("no cfg kill");
  a_step_single: assert property (step_pulse |=> !step_pulse) else $error("step long");
  a_end_step: assert property (sweep_end |-> step_pulse) else $error("end without step");
  // every change is one step, or a return to the start frequency
  a_step_delta: assert property (
    sweep_active && $past(sweep_active) && freq_word != $past(freq_word) |->
    freq_word == $past(freq_word) + step_size || freq_word == start_freq ||
    shape_tri && freq_word == $past(freq_word) - step_size) else $error("bad step");
  a_freq_range: assert property (
    sweep_active |-> freq_word >= start_freq &&
    {12'h000, freq_word} <= start_freq + step_count * step_size) else $error("range");
endmodule
bind fss_sweep fss_sweep_sva chk (.*);

// File: tb/fss_host.sv
// host model driving the trigger and abort pins
`timescale 1ns/1ps
module fss_host (
  input wire clock,
  output reg trigger_pin,
  output reg abort_pin
);
  initial begin
    trigger_pin = 1'b0;
    abort_pin = 1'b0;
  end
  // pin level changed just after the falling edge
  task hold(input v);
    begin
      @(negedge clock) trigger_pin = v;
    end
  endtask
  // start or step pulse, long enough for the synchroniser
  task pulse(input integer hi, input integer lo);
    begin
      hold(1'b1);
      repeat (hi) @(negedge clock);
      trigger_pin = 1'b0;
      repeat (lo) @(negedge clock);
    end
  endtask
  task kill;
    begin
      @(negedge clock) abort_pin = 1'b1;
      repeat (4) @(negedge clock);
      abort_pin = 1'b0;
      repeat (8) @(negedge clock);
    end
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the frequency sweep sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg config_load = 1'b0;
  reg [23:0] start_freq = 24'h000000;
  reg [23:0] step_size = 24'h000001;
  reg [11:0] step_count = 12'h001;
  reg [10:0] step_interval = 11'h004;
  reg [10:0] burst_len = 11'h002;
  reg interval_base = 1'b0;
  reg ext_pacing = 1'b0;
  reg shape_tri = 1'b0;
  reg [11:0] control_bits = 12'h000;
  reg pin_burst = 1'b0;
  reg wave_tick = 1'b0;
  wire trigger_pin, abort_pin, wave_enable, phase_clear, sweep_active, step_pulse, sweep_end;
  wire [23:0] freq_word;
  integer seed = 48;
  integer error_cnt = 0;
  integer checked = 0;
  integer cyc = 0;
  integer k, p, n, i, m;
  integer ends = 0;
  reg [23:0] q[$];
  reg [23:0] last;
  reg [23:0] e;
  fss_sweep uut (.*);
  fss_host host (.*);
  initial forever #4 clock = ~clock;
  // random phase-accumulator wraps for the wave-cycle interval base
  always @(negedge clock) wave_tick <= ($random(seed) & 3) == 0;
  // each new frequency is matched against the oldest note, sampled when settled
  always @(negedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      results;
    end
    if (sweep_end === 1'b1)
      ends++;
    if (sweep_active && freq_word !== last && q.size() > 0) begin
      e = q.pop_front();
      `CHK("freq_word", e, freq_word)
      `CHK("wave_on", 1'b1, wave_enable)
    end
    last = sweep_active ? freq_word : 24'hXXXXXX;
  end
  // two whole sweeps of a random profile, then abort
  task run(input x, input t, input b);
    begin
      ext_pacing = x;
      shape_tri = t;
      interval_base = b;
      step_count = 12'h001 + ($random(seed) & 3);
      start_freq = $random(seed) & 24'h00FFFF;
      step_size = 24'h000001 + ($random(seed) & 24'h000FFF);
      n = t ? 2 * step_count : step_count + 1;
      for (k = 0; k < 2 * n; k++) begin
        p = k % n;
        q.push_back(start_freq + step_size * (p > step_count ? n - p : p));
      end
      ends = 0;
      host.pulse(4, 8);
      for (i = 0; i < 400 && q.size() > 0; i++) begin
        if (x)
          host.pulse(6, 6);
        else
          @(negedge clock);
      end
      `CHK("sweep_done", 0, q.size())
      `CHK("sweep_end", (t && step_count > 12'h001) ? 2 : 1, ends)
      host.kill;
      `CHK("abort_idle", 2'b00, {sweep_active, wave_enable})
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    for (m = 0; m < 5; m++)
      run(m[0], m[1], m == 4);
    // burst mode: short burst, then midscale for the rest of each step
    ext_pacing = 1'b0;
    interval_base = 1'b0;
    step_interval = 11'h008;
    control_bits = 12'h080;
    host.pulse(4, 8);
    p = 0;
    repeat (40) @(negedge clock) p += !wave_enable;
    `CHK("burst_mid", 1'b1, p > 16)
    config_load = 1'b1;
    @(negedge clock);
    config_load = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("cfg_idle", 2'b00, {sweep_active, wave_enable})
    // pin-gated output follows the trigger level
    control_bits = 12'h000;
    pin_burst = 1'b1;
    host.hold(1'b1);
    repeat (8) @(negedge clock);
    `CHK("gate_high", 1'b1, wave_enable)
    host.hold(1'b0);
    repeat (8) @(negedge clock);
    `CHK("gate_low", 1'b0, wave_enable)
    host.kill;
    results;
  end
endmodule
